// ---- sswr_host_model.sv ----
// Host processor model that services the watchdog input
`timescale 1ns/1ps
`default_nettype none
module sswr_host_model (
  input  wire logic clk_i,     // Bench clock
  input  wire logic alive_i,   // High while host software runs
  input  wire logic use_i,     // High when the watchdog pin is driven
  output logic      wdog_o,    // Watchdog toggle level
  output logic      wdog_en_o  // Pin driven flag
);
  int cnt = 0;                 // Toggle spacing counter
  initial wdog_o = 1'b0;
  // toggle every 8 cycles, far inside timeout
  always @(negedge clk_i)
  begin
    cnt <= (cnt == 7) ? 0 : cnt + 1;
    // A floating pin shows no stable level, so it wanders
    if (!use_i)
      wdog_o <= ~wdog_o;
    else if (alive_i && cnt == 7)
      wdog_o <= ~wdog_o;
  end
  assign wdog_en_o = use_i;
endmodule // sswr_host_model
`default_nettype wire

// ---- sswr_params.svh ----
// Timing constants and counter width for the supply supervisor block
`ifndef SSWR_PARAMS_SVH
`define SSWR_PARAMS_SVH
// Clock period in picoseconds (25 MHz)
`define SSWR_CLK_PERIOD_PS 40000
// Reset hold delay in milliseconds
`define SSWR_HOLD_MS 180
// Hold delay in clock cycles: 180 ms at 40 ns per cycle
// Written out because the product in picoseconds overflows 32 bits
`define SSWR_HOLD_CYCLES 4500000
// Watchdog timeout in milliseconds (plain default)
`define SSWR_WDOG_MS 1600
// Watchdog timeout in clock cycles: 1600 ms at 40 ns per cycle
`define SSWR_WDOG_CYCLES 40000000
// Time base tick divider: one tick per microsecond
`define SSWR_TICK_DIV 25
// Counter width wide enough for either count in ticks or cycles
`define SSWR_CNT_W 32
`endif

// ---- sswr_pkg.sv ----
// Types shared by the supply supervisor block
package sswr_pkg;
  // Synchronised input flags travelling together
  typedef struct packed {
    logic undervolt;   // Supply below threshold
    logic manual_n;    // Manual reset level, low active
    logic wdog;        // Watchdog input level
  } sswr_inputs_type;
  // Reset sequencer states
  typedef enum logic [0:0] {
    SSWR_HOLD,
    SSWR_RUN
  } sswr_state_type;
endpackage

// ---- sswr_supervisor.sv ----
// Supply supervisor with manual reset, watchdog and reset hold delay
`include "sswr_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of the datapath:
// - Every pin except SRST_I passes two flip-flops before any decision reads it
// - Any present cause forces both reset outputs on the next edge
// - The hold counter restarts from zero on every cause, so a cause
//   that chatters keeps the outputs asserted for a full hold each time
// - The watchdog idle counter only runs while reset is released and
//   the host drives the pin; it saturates at the limit
// - Counting is per clock cycle; the clock is the internal time base
// Limitation: a cause shorter than one clock cycle may be missed by
// the synchronisers, which is accepted for slow analog flags
module sswr_supervisor
  import sswr_pkg::*;
#(
  parameter int HOLD_CYCLES = `SSWR_HOLD_CYCLES,  // Reset hold in cycles
  parameter int WDOG_CYCLES = `SSWR_WDOG_CYCLES   // Watchdog timeout
)
(
  input  wire logic CLK_I,            // 25 MHz clock
  input  wire logic SRST_I,           // Synchronous reset, high active
  input  wire logic UNDERVOLT_I,      // Comparator: supply below threshold
  input  wire logic MANUAL_RESET_IN_N_I, // Manual reset, low active
  input  wire logic WATCHDOG_TOGGLE_IN_I, // Watchdog toggle from host
  input  wire logic WATCHDOG_EN_I,    // High when the watchdog pin is driven
  output logic      RESET_N_O,        // Reset output, low active
  output logic      RESET_O           // Reset output, high active
);

  // Two-stage synchronisers for the asynchronous inputs
  sswr_inputs_type  sync1;            // First stage, read only by sync2
  sswr_inputs_type  sync2;            // Second stage, safe to use
  logic             wdog_prev;        // Previous synced watchdog level
  logic             wdog_en1;         // Enable sync, first stage
  logic             wdog_en2;         // Enable sync, second stage
  sswr_state_type   state;            // Hold or run
  logic [`SSWR_CNT_W-1:0] hold_cnt;   // Reset hold countdown
  logic [`SSWR_CNT_W-1:0] wdog_cnt;   // Watchdog idle counter
  logic             cause;            // A reset cause is present now
  logic             wdog_edge;        // Watchdog input changed level
  logic             wdog_expire;      // Watchdog timed out
  logic [`SSWR_CNT_W-1:0] quiet_cnt;  // Cycles with no cause present

  // Synchroniser chain; a floating watchdog is masked by the enable
  // comparator flag synchronised
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      sync1    <= '{undervolt: 1'b1, manual_n: 1'b1, wdog: 1'b0};
      sync2    <= '{undervolt: 1'b1, manual_n: 1'b1, wdog: 1'b0};
      wdog_en1 <= 1'b0;
      wdog_en2 <= 1'b0;
    end
    else
    begin
      sync1    <= '{undervolt: UNDERVOLT_I,
                    manual_n:  MANUAL_RESET_IN_N_I,
                    wdog:      WATCHDOG_TOGGLE_IN_I};
      sync2    <= sync1;
      wdog_en1 <= WATCHDOG_EN_I;
      wdog_en2 <= wdog_en1;
    end
  end

  // Edge detector on the synchronised watchdog level
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      wdog_prev <= 1'b0;
    else
      wdog_prev <= sync2.wdog;
  end

  assign wdog_edge   = (sync2.wdog != wdog_prev);
  assign wdog_expire = wdog_en2 && (wdog_cnt >= WDOG_CYCLES[`SSWR_CNT_W-1:0]);
  assign cause = sync2.undervolt || !sync2.manual_n || wdog_expire;

  // Watchdog counter; a floating pin (host duty) never times out
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      wdog_cnt <= '0;
    else if (state == SSWR_HOLD || !wdog_en2)
      wdog_cnt <= '0;
    else if (wdog_edge)
      wdog_cnt <= '0;
    else if (!wdog_expire)
      wdog_cnt <= wdog_cnt + 1'b1;
  end

  // Sequencer: any cause reloads the hold; release only when it expires
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      state    <= SSWR_HOLD;
      hold_cnt <= '0;
    end
    else
    begin
      unique case (state)
        SSWR_HOLD:
        begin
          if (cause)
            hold_cnt <= '0;
          else if (hold_cnt >= HOLD_CYCLES[`SSWR_CNT_W-1:0] - 1)
          begin
            state    <= SSWR_RUN;
            hold_cnt <= '0;
          end
          else
            hold_cnt <= hold_cnt + 1'b1;
        end
        SSWR_RUN:
        begin
          if (cause)
            state <= SSWR_HOLD;
        end
      endcase
    end
  end

  // Cycles since the last cause; an independent witness for the hold
  // hold length witness
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || cause)
      quiet_cnt <= '0;
    // Saturate so a long quiet run never wraps back to a short one
    else if (quiet_cnt != '1)
      quiet_cnt <= quiet_cnt + 1'b1;
  end

  // Outputs registered from the state; any cause also forces them on the next edge
  // high output held with low one
  // release only when the hold ends
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      RESET_N_O <= 1'b0;
      RESET_O   <= 1'b1;
    end
    else
    begin
      RESET_N_O <= !(cause || (state == SSWR_HOLD && !(hold_cnt >=
                     HOLD_CYCLES[`SSWR_CNT_W-1:0] - 1)));
      RESET_O   <= cause || (state == SSWR_HOLD && !(hold_cnt >=
                     HOLD_CYCLES[`SSWR_CNT_W-1:0] - 1));
    end
  end

  // Both outputs always complementary
  outs_compl_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    RESET_N_O == !RESET_O) else $error("reset outputs disagree");
  // Undervoltage asserts reset next cycle
  uv_asserts_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    sync2.undervolt |=> !RESET_N_O) else $error("undervolt no reset");
  // Manual reset asserts high output
  manual_forces_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !sync2.manual_n |=> RESET_O) else $error("manual no reset");
  // Release only after a quiet hold period
  hold_release_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    $rose(RESET_N_O) |-> hold_cnt == '0 && state == SSWR_RUN)
    else $error("release without hold");
  // Timer is zero the cycle after any held cycle
  wdog_clear_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    state == SSWR_HOLD |=> wdog_cnt == '0)
    else $error("wdog not clear");
  // Edge restarts the timer
  wdog_edge_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wdog_edge |=> wdog_cnt == '0) else $error("edge no restart");
  // Expiry leads to reset
  wdog_trip_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    wdog_expire |=> !RESET_N_O ##1 state == SSWR_HOLD)
    else $error("timeout no reset");
  // Cause in run moves to hold
  run_to_hold_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    state == SSWR_RUN && cause |=> state == SSWR_HOLD && hold_cnt == '0)
    else $error("no reload");
  // Release comes no sooner than a full hold after the last cause
  hold_length_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    $rose(RESET_N_O) |-> quiet_cnt >= HOLD_CYCLES[`SSWR_CNT_W-1:0] - 1)
    else $error("hold too short");
  // Any cause drives the high output next cycle
  cause_high_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    cause |=> RESET_O)
    else $error("cause no high reset");
  // Released outputs only in the run state
  run_level_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    RESET_N_O |-> state == SSWR_RUN)
    else $error("released while held");
  // A cause during the hold restarts it from zero
  hold_reload_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    state == SSWR_HOLD && cause |=> hold_cnt == '0)
    else $error("hold not restarted");
  // An unused watchdog pin keeps the timer at zero
  wdog_off_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
    !wdog_en2 |=> wdog_cnt == '0)
    else $error("unused wdog counts");

endmodule // sswr_supervisor
`default_nettype wire

// ---- supply_supervisor_watchdog_reset_test.sv ----
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("mismatch %s exp %b got %b", nm, e, g); end end
module supply_supervisor_watchdog_reset_test;
  localparam int HOLD = 20;   // Shortened hold delay
  localparam int WDOG = 50;   // Shortened watchdog timeout
  logic clk, srst, uv, mr_n, alive, use_wd;
  wire logic wd, wd_en, rst_n, rst;
  int fail_count = 0, comparisons = 0, seed, n, i;
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  sswr_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) i_dut (
    .CLK_I(clk), .SRST_I(srst), .UNDERVOLT_I(uv),
    .MANUAL_RESET_IN_N_I(mr_n), .WATCHDOG_TOGGLE_IN_I(wd),
    .WATCHDOG_EN_I(wd_en), .RESET_N_O(rst_n), .RESET_O(rst));
  sswr_host_model i_host (.clk_i(clk), .alive_i(alive), .use_i(use_wd),
    .wdog_o(wd), .wdog_en_o(wd_en));
  // Still held shortly before the hold ends, free soon after
  task automatic wait_rel(input int lo);
    repeat (lo) @(negedge clk);
    `CHK("held", 1'b0, rst_n)
    for (i = 0; i < 10 && rst_n !== 1'b1; i++) @(negedge clk);
    `CHK("released", 1'b1, rst_n)
    `CHK("pair", ~rst_n, rst)
  endtask
  // Cause 0 is low supply, cause 1 the manual input
  task automatic pulse(input int which, input int len);
    if (which == 0) uv = 1'b1; else mr_n = 1'b0;
    repeat (len) @(negedge clk);
    `CHK("rst_high", 1'b1, rst)
    `CHK("rst_low", 1'b0, rst_n)
    if (which == 0) uv = 1'b0; else mr_n = 1'b1;
    wait_rel(HOLD - 2);
  endtask
  task automatic results;
    $display("counts: %0d compared, %0d failed", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    srst = 1'b1; uv = 1'b0; mr_n = 1'b1; alive = 1'b1; use_wd = 1'b1;
    seed = 32'h08B2;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    wait_rel(HOLD - 2);
    $display("test power_up done");
    // Random cause lengths, the first two at the 4 cycle minimum
    for (n = 0; n < 8; n++)
      pulse(n % 2, n < 2 ? 4 : 4 + ($unsigned($random(seed)) % 40));
    $display("test causes done");
    repeat (3 * WDOG) @(negedge clk);
    `CHK("alive_quiet", 1'b1, rst_n)
    alive = 1'b0;
    for (i = 0; i < WDOG + 12 && rst !== 1'b1; i++) @(negedge clk);
    `CHK("wdog_fire", 1'b1, rst)
    alive = 1'b1;
    wait_rel(HOLD - 2);
    alive = 1'b0;
    repeat (WDOG - 10) @(negedge clk);
    `CHK("wdog_cleared", 1'b1, rst_n)
    use_wd = 1'b0;
    repeat (3 * WDOG) @(negedge clk);
    `CHK("wdog_unused", 1'b1, rst_n)
    $display("test watchdog done");
    results;
  end
endmodule // supply_supervisor_watchdog_reset_test
`default_nettype wire
